// ===== src/tevg_regs.vh
// register offsets, field positions and reset values for the timer event/compare block
`ifndef TEVG_REGS_VH
`define TEVG_REGS_VH
`define TEVG_T1_EVENT_ADDR 32'h4000e014
`define TEVG_T1_MODE_ADDR 32'h4000e018
`define TEVG_T2_EVENT_ADDR 32'h4000f014
`define TEVG_T2_MODE_ADDR 32'h4000f018
`define TEVG_T1_COUNT_ADDR 32'h4000e01c
`define TEVG_T2_COUNT_ADDR 32'h4000f01c
`define TEVG_T1_FLAG_ADDR 32'h4000e020
`define TEVG_T2_FLAG_ADDR 32'h4000f020
`define TEVG_T1_MASK_ADDR 32'h4000e024
`define TEVG_T2_MASK_ADDR 32'h4000f024
`define TEVG_T1_CMP1_ADDR 32'h4000e028
`define TEVG_T2_CMP1_ADDR 32'h4000f028
`define TEVG_T1_CMP2_ADDR 32'h4000e02c
`define TEVG_T2_CMP2_ADDR 32'h4000f02c
`define TEVG_T1_CTRL_ADDR 32'h4000e030
`define TEVG_T2_CTRL_ADDR 32'h4000f030
`define TEVG_T1_ARR_ADDR 32'h4000e034
`define TEVG_T2_ARR_ADDR 32'h4000f034
// event generate bits
`define TEVG_UG_BIT 0
`define TEVG_CC1G_BIT 1
`define TEVG_CC2G_BIT 2
`define TEVG_TG_BIT 6
// flag register layout
`define TEVG_FLAG_UPD 0
`define TEVG_FLAG_CC1 1
`define TEVG_FLAG_CC2 2
`define TEVG_FLAG_TRG 6
`define TEVG_FLAG_OVR1 9
`define TEVG_FLAG_OVR2 10
`define TEVG_FLAG_W 11
// mode register fields
`define TEVG_MODE_W 15
`define TEVG_SEL1_LO 0
`define TEVG_SEL1_HI 1
`define TEVG_OM1_LO 4
`define TEVG_OM1_HI 6
`define TEVG_SEL2_LO 8
`define TEVG_SEL2_HI 9
`define TEVG_OM2_LO 12
`define TEVG_OM2_HI 14
// control register bits
`define TEVG_CTRL_EN 0
`define TEVG_CTRL_DIR 1
`define TEVG_CTRL_CTR 2
`define TEVG_CTRL_POL1 3
`define TEVG_CTRL_POL2 4
`define TEVG_CTRL_PSC_LO 8
`define TEVG_CTRL_PSC_HI 15
`define TEVG_CTRL_W 16
// output compare modes
`define TEVG_OM_FROZEN 3'h0
`define TEVG_OM_SET 3'h1
`define TEVG_OM_CLR 3'h2
`define TEVG_OM_TOG 3'h3
`define TEVG_OM_LOW 3'h4
`define TEVG_OM_HIGH 3'h5
`define TEVG_OM_PWM1 3'h6
`define TEVG_OM_PWM2 3'h7
`define TEVG_SEL_OUT 2'h0
`define TEVG_RESET_VAL 32'h00000000
`endif

// ===== src/tevg_top.v
// two timer instances: event generation strobes, capture/compare modes, apb slave
`timescale 1ns/100ps
`include "tevg_regs.vh"

module tevg_top #(
    parameter CNT_W = 16, // counter width
    parameter PSC_W = 8 // prescaler width
) (
    input wire clock, // 25 MHz clock
    input wire reset, // async active high
    input wire psel, // apb select
    input wire penable, // apb enable
    input wire pwrite, // apb direction
    input wire [31:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error
    output reg [1:0] chan1_out_pin, // channel 1 pin per timer
    output reg [1:0] chan2_out_pin, // channel 2 pin per timer
    output reg [1:0] irq // interrupt per timer
);

    // --------------------------------------------------------------
    // bus decode
    // --------------------------------------------------------------
    // zero-wait slave: each access completes in its first access cycle
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    // lists of addresses per timer, indexed by instance
    wire [31:0] a_evt [0:1];
    wire [31:0] a_mode [0:1];
    wire [31:0] a_cnt [0:1];
    wire [31:0] a_flag [0:1];
    wire [31:0] a_mask [0:1];
    wire [31:0] a_cmp1 [0:1];
    wire [31:0] a_cmp2 [0:1];
    wire [31:0] a_ctrl [0:1];
    wire [31:0] a_arr [0:1];
    assign a_evt[0] = `TEVG_T1_EVENT_ADDR;
    assign a_evt[1] = `TEVG_T2_EVENT_ADDR;
    assign a_mode[0] = `TEVG_T1_MODE_ADDR;
    assign a_mode[1] = `TEVG_T2_MODE_ADDR;
    assign a_cnt[0] = `TEVG_T1_COUNT_ADDR;
    assign a_cnt[1] = `TEVG_T2_COUNT_ADDR;
    assign a_flag[0] = `TEVG_T1_FLAG_ADDR;
    assign a_flag[1] = `TEVG_T2_FLAG_ADDR;
    assign a_mask[0] = `TEVG_T1_MASK_ADDR;
    assign a_mask[1] = `TEVG_T2_MASK_ADDR;
    assign a_cmp1[0] = `TEVG_T1_CMP1_ADDR;
    assign a_cmp1[1] = `TEVG_T2_CMP1_ADDR;
    assign a_cmp2[0] = `TEVG_T1_CMP2_ADDR;
    assign a_cmp2[1] = `TEVG_T2_CMP2_ADDR;
    assign a_ctrl[0] = `TEVG_T1_CTRL_ADDR;
    assign a_ctrl[1] = `TEVG_T2_CTRL_ADDR;
    assign a_arr[0] = `TEVG_T1_ARR_ADDR;
    assign a_arr[1] = `TEVG_T2_ARR_ADDR;

    wire [31:0] rdata_t [0:1];
    wire [1:0] hit;

    genvar t;
    generate
        for (t = 0; t < 2; t = t + 1) begin : g_tim
            // ------------------------------------------------------
            // per-timer registers
            // ------------------------------------------------------
            reg [`TEVG_MODE_W-1:0] chan_mode;
            reg [`TEVG_CTRL_W-1:0] ctrl;
            reg [CNT_W-1:0] auto_reload_value;
            reg [CNT_W-1:0] counter_value;
            reg [PSC_W-1:0] psc_count;
            reg [CNT_W-1:0] chan1_compare_value;
            reg [CNT_W-1:0] chan2_compare_value;
            reg [CNT_W-1:0] cmp1_shadow;
            reg [CNT_W-1:0] cmp2_shadow;
            reg [`TEVG_FLAG_W-1:0] timer_irq_flags;
            reg [`TEVG_FLAG_W-1:0] irq_mask;
            reg chan1_out_reference;
            reg chan2_out_reference;
            reg [2:0] om1_prev;
            reg [2:0] om2_prev;
            reg cmp1_lt_prev;
            reg cmp2_lt_prev;
            reg up_prev;

            wire s_evt = a_evt[t] == paddr;
            wire s_mode = a_mode[t] == paddr;
            wire s_cnt = a_cnt[t] == paddr;
            wire s_flag = a_flag[t] == paddr;
            wire s_mask = a_mask[t] == paddr;
            wire s_cmp1 = a_cmp1[t] == paddr;
            wire s_cmp2 = a_cmp2[t] == paddr;
            wire s_ctrl = a_ctrl[t] == paddr;
            wire s_arr = a_arr[t] == paddr;
            assign hit[t] = s_evt | s_mode | s_cnt | s_flag | s_mask | s_cmp1 | s_cmp2 | s_ctrl | s_arr;

            // event strobes exist only in the write cycle, never stored
            wire evt_wr = wr & s_evt;
            wire update_event_strobe = evt_wr & pwdata[`TEVG_UG_BIT];
            wire chan1_event_strobe = evt_wr & pwdata[`TEVG_CC1G_BIT];
            wire chan2_event_strobe = evt_wr & pwdata[`TEVG_CC2G_BIT];
            wire trigger_event_strobe = evt_wr & pwdata[`TEVG_TG_BIT];

            wire [1:0] sel1 = chan_mode[`TEVG_SEL1_HI:`TEVG_SEL1_LO];
            wire [1:0] sel2 = chan_mode[`TEVG_SEL2_HI:`TEVG_SEL2_LO];
            // output fields act only when selection is zero
            wire out1 = sel1 == `TEVG_SEL_OUT;
            wire out2 = sel2 == `TEVG_SEL_OUT;
            wire [2:0] om1 = chan_mode[`TEVG_OM1_HI:`TEVG_OM1_LO];
            wire [2:0] om2 = chan_mode[`TEVG_OM2_HI:`TEVG_OM2_LO];
            wire count_direction = ctrl[`TEVG_CTRL_DIR];
            wire centre = ctrl[`TEVG_CTRL_CTR];
            wire enable = ctrl[`TEVG_CTRL_EN];
            wire [PSC_W-1:0] psc_ratio = ctrl[`TEVG_CTRL_PSC_HI:`TEVG_CTRL_PSC_LO];
            // centre mode here runs up then down between zero and reload
            wire counting_up = centre ? up_prev : ~count_direction;
            wire tick = enable & (psc_count == psc_ratio);
            wire at_top = counter_value == auto_reload_value;
            wire at_zero = counter_value == {CNT_W{1'b0}};
            wire hw_update = tick & (centre ? 1'b0 : (counting_up ? at_top : at_zero));
            wire match1 = counter_value == cmp1_shadow;
            wire match2 = counter_value == cmp2_shadow;
            wire lt1 = counter_value < cmp1_shadow;
            wire lt2 = counter_value < cmp2_shadow;
            wire gt1 = counter_value > cmp1_shadow;
            wire gt2 = counter_value > cmp2_shadow;
            wire cap1 = chan1_event_strobe & ~out1;
            wire cap2 = chan2_event_strobe & ~out2;

            // ------------------------------------------------------
            // counter and prescaler
            // ------------------------------------------------------
            // counter, prescaler and centre direction; a software update
            // restarts the prescaler count so the next period is whole,
            // while the programmed ratio in ctrl is left untouched
            always @(posedge clock or posedge reset) begin
                if (reset) begin
                    counter_value <= {CNT_W{1'b0}};
                    psc_count <= {PSC_W{1'b0}};
                    up_prev <= 1'b1;
                end else if (update_event_strobe) begin
                    psc_count <= {PSC_W{1'b0}};
                    up_prev <= 1'b1;
                    if (centre | ~count_direction) begin
                        counter_value <= {CNT_W{1'b0}};
                    end else begin
                        counter_value <= auto_reload_value;
                    end
                end else if (wr & s_cnt) begin
                    counter_value <= pwdata[CNT_W-1:0];
                end else if (enable) begin
                    psc_count <= tick ? {PSC_W{1'b0}} : psc_count + 1'b1;
                    if (tick) begin
                        if (counting_up) begin
                            if (at_top) begin
                                counter_value <= centre ? counter_value - 1'b1 : {CNT_W{1'b0}};
                                up_prev <= ~centre;
                            end else begin
                                counter_value <= counter_value + 1'b1;
                            end
                        end else begin
                            if (at_zero) begin
                                counter_value <= centre ? counter_value + 1'b1 : auto_reload_value;
                                up_prev <= 1'b1;
                            end else begin
                                counter_value <= counter_value - 1'b1;
                            end
                        end
                    end
                end
            end

            // ------------------------------------------------------
            // configuration and compare buffers
            // ------------------------------------------------------
            // control, reload, compare buffers and shadows
            // limitation: centre-aligned counting raises no hardware update,
            // so the shadows then load only on a software update
            always @(posedge clock or posedge reset) begin
                if (reset) begin
                    chan_mode <= {`TEVG_MODE_W{1'b0}};
                    ctrl <= {`TEVG_CTRL_W{1'b0}};
                    auto_reload_value <= {CNT_W{1'b1}};
                    chan1_compare_value <= {CNT_W{1'b0}};
                    chan2_compare_value <= {CNT_W{1'b0}};
                    cmp1_shadow <= {CNT_W{1'b0}};
                    cmp2_shadow <= {CNT_W{1'b0}};
                    irq_mask <= {`TEVG_FLAG_W{1'b0}};
                end else begin
                    if (wr & s_mode) chan_mode <= pwdata[`TEVG_MODE_W-1:0];
                    if (wr & s_ctrl) ctrl <= pwdata[`TEVG_CTRL_W-1:0];
                    if (wr & s_arr) auto_reload_value <= pwdata[CNT_W-1:0];
                    if (wr & s_mask) irq_mask <= pwdata[`TEVG_FLAG_W-1:0];
                    // capture takes priority over a software write the same cycle
                    if (cap1) begin
                        chan1_compare_value <= counter_value;
                    end else if (wr & s_cmp1) begin
                        chan1_compare_value <= pwdata[CNT_W-1:0];
                    end
                    if (cap2) begin
                        chan2_compare_value <= counter_value;
                    end else if (wr & s_cmp2) begin
                        chan2_compare_value <= pwdata[CNT_W-1:0];
                    end
                    // buffered compare values move to shadows on any update
                    if (update_event_strobe | hw_update) begin
                        cmp1_shadow <= chan1_compare_value;
                        cmp2_shadow <= chan2_compare_value;
                    end
                end
            end

            // ------------------------------------------------------
            // interrupt flags
            // ------------------------------------------------------
            // sticky flags: hardware set wins over read clear
            wire [`TEVG_FLAG_W-1:0] set_flags;
            assign set_flags[`TEVG_FLAG_UPD] = update_event_strobe | hw_update;
            assign set_flags[`TEVG_FLAG_CC1] = chan1_event_strobe | (out1 & match1 & tick);
            assign set_flags[`TEVG_FLAG_CC2] = chan2_event_strobe | (out2 & match2 & tick);
            assign set_flags[5:3] = 3'h0;
            assign set_flags[`TEVG_FLAG_TRG] = trigger_event_strobe;
            assign set_flags[8:7] = 2'h0;
            assign set_flags[`TEVG_FLAG_OVR1] = cap1 & timer_irq_flags[`TEVG_FLAG_CC1];
            assign set_flags[`TEVG_FLAG_OVR2] = cap2 & timer_irq_flags[`TEVG_FLAG_CC2];
            always @(posedge clock or posedge reset) begin
                if (reset) begin
                    timer_irq_flags <= {`TEVG_FLAG_W{1'b0}};
                end else if (rd & s_flag) begin
                    // clear only what the read returned: a set that landed in the
                    // setup cycle was not seen by software yet and must stay
                    timer_irq_flags <= set_flags | (timer_irq_flags & ~prdata[`TEVG_FLAG_W-1:0]);
                end else begin
                    timer_irq_flags <= timer_irq_flags | set_flags;
                end
            end

            // ------------------------------------------------------
            // output reference
            // ------------------------------------------------------
            // reference generation for both channels
            // toggle waits for a counting tick, so a stopped counter sitting
            // on the compare value does not toggle on every clock
            always @(posedge clock or posedge reset) begin
                if (reset) begin
                    chan1_out_reference <= 1'b0;
                    chan2_out_reference <= 1'b0;
                    om1_prev <= `TEVG_OM_FROZEN;
                    om2_prev <= `TEVG_OM_FROZEN;
                    cmp1_lt_prev <= 1'b0;
                    cmp2_lt_prev <= 1'b0;
                end else begin
                    om1_prev <= om1;
                    om2_prev <= om2;
                    cmp1_lt_prev <= counting_up ? lt1 : ~gt1;
                    cmp2_lt_prev <= counting_up ? lt2 : ~gt2;
                    if (out1) begin
                        case (om1)
                            `TEVG_OM_FROZEN: chan1_out_reference <= chan1_out_reference;
                            `TEVG_OM_SET: if (match1) chan1_out_reference <= 1'b1;
                            `TEVG_OM_CLR: if (match1) chan1_out_reference <= 1'b0;
                            `TEVG_OM_TOG: if (match1 & tick) chan1_out_reference <= ~chan1_out_reference;
                            `TEVG_OM_LOW: chan1_out_reference <= 1'b0;
                            `TEVG_OM_HIGH: chan1_out_reference <= 1'b1;
                            `TEVG_OM_PWM1, `TEVG_OM_PWM2: begin
                                // level moves only on a comparison change or on entering a pwm mode from any other mode
                                if ((om1_prev == `TEVG_OM_FROZEN) ||
                                    (cmp1_lt_prev != (counting_up ? lt1 : ~gt1)) ||
                                    (om1_prev != om1)) begin
                                    chan1_out_reference <= (om1 == `TEVG_OM_PWM1) ?
                                        (counting_up ? lt1 : ~gt1) :
                                        (counting_up ? ~lt1 : gt1);
                                end
                            end
                            default: chan1_out_reference <= chan1_out_reference;
                        endcase
                    end
                    if (out2) begin
                        case (om2)
                            `TEVG_OM_FROZEN: chan2_out_reference <= chan2_out_reference;
                            `TEVG_OM_SET: if (match2) chan2_out_reference <= 1'b1;
                            `TEVG_OM_CLR: if (match2) chan2_out_reference <= 1'b0;
                            `TEVG_OM_TOG: if (match2 & tick) chan2_out_reference <= ~chan2_out_reference;
                            `TEVG_OM_LOW: chan2_out_reference <= 1'b0;
                            `TEVG_OM_HIGH: chan2_out_reference <= 1'b1;
                            `TEVG_OM_PWM1, `TEVG_OM_PWM2: begin
                                if ((om2_prev == `TEVG_OM_FROZEN) ||
                                    (cmp2_lt_prev != (counting_up ? lt2 : ~gt2)) ||
                                    (om2_prev != om2)) begin
                                    chan2_out_reference <= (om2 == `TEVG_OM_PWM1) ?
                                        (counting_up ? lt2 : ~gt2) :
                                        (counting_up ? ~lt2 : gt2);
                                end
                            end
                            default: chan2_out_reference <= chan2_out_reference;
                        endcase
                    end
                end
            end

            // ------------------------------------------------------
            // pins and interrupt
            // ------------------------------------------------------
            // pins and interrupt, all registered; input channels drive low
            // the irq looks at new sets too, so it rises in the same cycle as the flags
            always @(posedge clock or posedge reset) begin
                if (reset) begin
                    chan1_out_pin[t] <= 1'b0;
                    chan2_out_pin[t] <= 1'b0;
                    irq[t] <= 1'b0;
                end else begin
                    chan1_out_pin[t] <= out1 & (chan1_out_reference ^ ctrl[`TEVG_CTRL_POL1]);
                    chan2_out_pin[t] <= out2 & (chan2_out_reference ^ ctrl[`TEVG_CTRL_POL2]);
                    irq[t] <= |((timer_irq_flags | set_flags) & irq_mask);
                end
            end

            // ------------------------------------------------------
            // read data
            // ------------------------------------------------------
            // read mux; event register reads as zero
            // the other timer's decode gives zero, so the two can be ored
            assign rdata_t[t] =
                s_mode ? {{(32-`TEVG_MODE_W){1'b0}}, chan_mode} :
                s_ctrl ? {{(32-`TEVG_CTRL_W){1'b0}}, ctrl} :
                s_cnt ? {{(32-CNT_W){1'b0}}, counter_value} :
                s_arr ? {{(32-CNT_W){1'b0}}, auto_reload_value} :
                s_cmp1 ? {{(32-CNT_W){1'b0}}, chan1_compare_value} :
                s_cmp2 ? {{(32-CNT_W){1'b0}}, chan2_compare_value} :
                s_flag ? {{(32-`TEVG_FLAG_W){1'b0}}, timer_irq_flags} :
                s_mask ? {{(32-`TEVG_FLAG_W){1'b0}}, irq_mask} :
                32'h00000000;
        end
    endgenerate

    // --------------------------------------------------------------
    // apb response
    // --------------------------------------------------------------
    // ready in setup cycle's follower; unmapped addresses answer with error
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~(|hit);
            prdata <= (psel & ~penable & ~pwrite) ? (rdata_t[0] | rdata_t[1]) : 32'h00000000;
        end
    end

endmodule // tevg_top

// ===== test/tevg_sva.sv
// assertion checker on the apb slave and outputs of the timer block
`timescale 1ns/100ps
`include "tevg_regs.vh"
module tevg_sva (
    input wire clock, // peripheral clock
    input wire reset, // async reset
    input wire psel, // apb select
    input wire penable, // apb enable
    input wire pwrite, // apb direction
    input wire [31:0] paddr, // apb address
    input wire [31:0] pwdata, // apb write data
    input wire [31:0] prdata, // apb read data
    input wire pready, // apb ready
    input wire pslverr, // apb error
    input wire [1:0] chan1_out_pin, // channel 1 pins
    input wire [1:0] chan2_out_pin, // channel 2 pins
    input wire [1:0] irq // interrupt per timer
);
    // ----------
    // bus and output checks
    // ----------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    // completing reads of the event or mode register of either timer
    wire rd_done = pready && !pwrite;
    wire ev_hit = paddr == `TEVG_T1_EVENT_ADDR || paddr == `TEVG_T2_EVENT_ADDR;
    wire md_hit = paddr == `TEVG_T1_MODE_ADDR || paddr == `TEVG_T2_MODE_ADDR;
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_unmapped_reads_zero: assert property (rd_done && pslverr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_event_reads_zero: assert property (rd_done && ev_hit |-> prdata == 32'h0 && !pslverr)
        else $error("event register read not zero");
    a_mode_upper_zero: assert property (rd_done && md_hit |-> prdata[31:15] == 17'h0 && !pslverr)
        else $error("mode register upper bits set");
    // outputs must leave reset quiet, before any register is written
    a_reset_quiet: assert property ($fell(reset) |-> irq == 2'h0 && chan1_out_pin == 2'h0 && chan2_out_pin == 2'h0)
        else $error("outputs active after reset");
endmodule // tevg_sva
bind tevg_top tevg_sva tevg_sva_inst (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .chan1_out_pin, .chan2_out_pin, .irq);

// ===== test/tevg_top_test.sv
// self-checking bench for the two-timer event and compare block
`timescale 1ns/100ps
module tevg_top_test;
    // ----------
    // signals and design
    // ----------
    reg clock = 1'b0;
    reg reset = 1'b1;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [31:0] paddr = 32'h0;
    reg [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [1:0] chan1_out_pin;
    wire [1:0] chan2_out_pin;
    wire [1:0] irq;
    reg [31:0] rdata;
    reg rerr;
    reg [31:0] b;
    integer failures = 0;
    integer check_count = 0;
    integer t;
    integer i;
    // mode codes in order, octal digits, and the pin each leaves with counter and compare at zero
    localparam [20:0] MODES = 21'o1025476;
    localparam [6:0] PINS = 7'b1101010;
    always #20 clock = ~clock;
    tevg_top tevg_top_inst (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .chan1_out_pin, .chan2_out_pin, .irq);
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", check_count, failures);
            if (failures == 0 && check_count > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // one apb transfer, held until ready is seen at a rising edge, then an idle cycle
    task apb(input w, input [31:0] a, input [31:0] d);
        integer n;
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clock);
            penable <= 1'b1;
            n = 0;
            @(posedge clock);
            while (pready !== 1'b1 && n < 16) begin
                n = n + 1;
                @(posedge clock);
            end
            rdata = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            if (n == 16) begin
                failures = failures + 1;
                end_of_test;
            end
            @(posedge clock);
        end
    endtask
    task wr(input [31:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input [31:0] a, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            chk(rdata, e);
        end
    endtask
    // pins are registered, so allow a few cycles for the new level
    task pin(input e);
        integer n;
        begin
            n = 0;
            while (chan1_out_pin[t] !== e && n < 8) begin
                n = n + 1;
                @(posedge clock);
            end
            chk({31'h0, chan1_out_pin[t]}, {31'h0, e});
        end
    endtask
    // ----------
    // tests, run on each timer in turn
    // ----------
    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        for (t = 0; t < 2; t = t + 1) begin
            b = t ? 32'h4000f000 : 32'h4000e000;
            rd(b + 32'h18, 32'h0);
            rd(b + 32'h14, 32'h0);
            wr(b + 32'h18, 32'h7733);
            rd(b + 32'h18, 32'h7733);
            rd(b + 32'h38, 32'h0);
            chk({31'h0, rerr}, 32'h1);
            $display("timer %0d registers done", t);
            wr(b + 32'h24, 32'h40);
            wr(b + 32'h14, 32'h0);
            rd(b + 32'h20, 32'h0);
            wr(b + 32'h14, 32'h40);
            chk({30'h0, irq}, {30'h0, 2'b01 << t});
            rd(b + 32'h20, 32'h40);
            rd(b + 32'h14, 32'h0);
            chk({30'h0, irq}, 32'h0);
            wr(b + 32'h24, 32'h0);
            wr(b + 32'h14, 32'h40);
            chk({30'h0, irq}, 32'h0);
            rd(b + 32'h20, 32'h40);
            $display("timer %0d trigger done", t);
            wr(b + 32'h18, 32'h0);
            wr(b + 32'h14, 32'h2);
            rd(b + 32'h20, 32'h2);
            wr(b + 32'h34, 32'h1234);
            wr(b + 32'h30, 32'h2);
            wr(b + 32'h14, 32'h1);
            rd(b + 32'h1c, 32'h1234);
            wr(b + 32'h18, 32'h1);
            wr(b + 32'h14, 32'h2);
            rd(b + 32'h28, 32'h1234);
            wr(b + 32'h14, 32'h2);
            rd(b + 32'h20, 32'h203);
            wr(b + 32'h30, 32'h0);
            wr(b + 32'h14, 32'h1);
            rd(b + 32'h1c, 32'h0);
            $display("timer %0d capture done", t);
            // zero compare reaches the shadow only through the update
            wr(b + 32'h28, 32'h0);
            wr(b + 32'h14, 32'h1);
            for (i = 0; i < 7; i = i + 1) begin
                wr(b + 32'h18, {25'h0, MODES[3 * (6 - i) +: 3], 4'h0});
                pin(PINS[6 - i]);
            end
            wr(b + 32'h18, 32'h50);
            pin(1'b1);
            wr(b + 32'h30, 32'h8);
            pin(1'b0);
            wr(b + 32'h30, 32'h0);
            for (i = 0; i < 4; i = i + 1) begin
                wr(b + 32'h18, 32'h50 | i);
                pin(i == 0);
            end
            wr(b + 32'h18, 32'h5000);
            repeat (2) @(posedge clock);
            chk({31'h0, chan2_out_pin[t]}, 32'h1);
            wr(b + 32'h30, 32'h10);
            repeat (2) @(posedge clock);
            chk({31'h0, chan2_out_pin[t]}, 32'h0);
            // toggle on a tick at the zero compare; the update restarts the prescaler
            wr(b + 32'h18, 32'h30);
            wr(b + 32'h30, 32'hff01);
            repeat (200) @(posedge clock);
            wr(b + 32'h14, 32'h1);
            rd(b + 32'h30, 32'hff01);
            repeat (200) @(posedge clock);
            chk({31'h0, chan1_out_pin[t]}, 32'h1);
            repeat (100) @(posedge clock);
            chk({31'h0, chan1_out_pin[t]}, 32'h0);
            wr(b + 32'h30, 32'h0);
            $display("timer %0d modes done", t);
        end
        end_of_test;
    end
endmodule // tevg_top_test
